// >>> qspi_regs_pkg.sv
// Constants for the queued serial port status bank and RAM window.
// Assumes a 32-bit classic Wishbone slave with 16-bit registers in the low lanes.
package qspi_regs_pkg;
    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int ADR_W = 5;               // Byte address width
    localparam int DAT_W = 32;              // Bus data width
    localparam int SEL_W = 4;               // Byte lanes
    localparam int REG_W = 16;              // Register width
    // Register byte offsets
    localparam logic [4:0] OFS_IRQ  = 5'h00;
    localparam logic [4:0] OFS_PTR  = 5'h04;
    localparam logic [4:0] OFS_DATA = 5'h08;
    localparam logic [4:0] OFS_DLY  = 5'h0c;
    // ----------------------------------------
    // Status and control field positions
    // ----------------------------------------
    localparam int B_COL_BE   = 15;         // collision_buserr_en
    localparam int B_ABT_BE   = 14;         // abort_buserr_en
    localparam int B_ABT_LOCK = 12;         // abort_lockout
    localparam int B_COL_IE   = 11;         // collision_irq_en
    localparam int B_ABT_IE   = 10;         // abort_irq_en
    localparam int B_FIN_IE   = 8;          // finished_irq_en
    localparam int B_COL_F    = 3;          // collision_flag
    localparam int B_ABT_F    = 2;          // abort_flag
    localparam int B_FIN_F    = 0;          // finished_flag
    localparam int B_SPE      = 15;         // transfer_enable in delay reg
    localparam int DLY_W      = 15;         // Delay fields below enable
    localparam logic [15:0] IRQ_CTRL_MASK = 16'hdd00;
    localparam logic [15:0] RST_16        = 16'h0000;
    localparam logic [31:0] RST_32        = 32'h0000_0000;
    // ----------------------------------------
    // Internal RAM layout
    // ----------------------------------------
    localparam int RAM_AW = 6;              // RAM index width
    localparam int RAM_N  = 64;             // Entries incl. reserved
    localparam int ENT_W  = 4;              // Queue entry index width
    localparam logic [1:0] SEC_TX  = 2'h0;  // 0x00-0x0F
    localparam logic [1:0] SEC_RX  = 2'h1;  // 0x10-0x1F
    localparam logic [1:0] SEC_CMD = 2'h2;  // 0x20-0x2F
    localparam logic [1:0] SEC_RSV = 2'h3;  // 0x30-0x3F
    localparam logic [9:0] PTR_HI_ZERO = 10'h000;
    localparam logic [15:0] PTR_STEP   = 16'h0001;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
endpackage : qspi_regs_pkg

// >>> queued_spi_status_and_ram_port.sv
// Status/interrupt-control bank, transfer enable and indirect RAM window.
// Assumes the serial engine reports busy, current entry and command completion
// synchronously to i_clk, and reads its RAM through the engine port.
//
// Behaviour
// - Flag CPU writes to executing RAM entry
// - Collision write errors when its enable set
// - Clearing enable mid-transfer errors when enabled
// - Lock-out stops CPU clearing transfer enable
// - Collision interrupt gated by its enable
// - Abort interrupt gated by its enable
// - Finished interrupt gated by its enable
// - Collision flag sticky, write one clears
// - Abort flag on CPU clear, one clears
// - Finished on end entry or halt
// - Wrap mode sets finished every end pass
// - RAM split tx, rx, command, reserved
// - Data write stores then advances pointer
// - Data read returns, advances, one wait
// - Pointer never wraps at section end
// - Command RAM uses upper byte only
// - Device clears enable when transfer ends
// - Halt stops after the current command
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module queued_spi_status_and_ram_port (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    // Wishbone classic slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [4:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_wb_err,
    // Serial engine side
    input  wire logic        i_busy,
    input  wire logic        i_cmd_done,
    input  wire logic [3:0]  i_cur_entry,
    input  wire logic        i_halt,
    input  wire logic        i_wrap_en,
    input  wire logic [3:0]  i_end_of_queue_pointer,
    input  wire logic [5:0]  i_eng_addr,
    output logic      [15:0] o_eng_rdata,
    input  wire logic        i_rx_we,
    input  wire logic [3:0]  i_rx_entry,
    input  wire logic [15:0] i_rx_data,
    // Control and interrupt
    output logic             o_transfer_enable,
    output logic      [14:0] o_delay_cfg,
    output logic             o_irq
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  sel);
        merge16 = {sel[1] ? new_v[15:8] : old_v[15:8],
                   sel[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction : merge16

    // Write-one-to-clear with the set winning
    function automatic logic w1c(input logic flag,
                                 input logic clr,
                                 input logic set);
        w1c = (flag & ~clr) | set;
    endfunction : w1c

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [15:0] irq_status_control;           // Control bits only
    logic [15:0] ram_pointer_reg;              // Auto-increment pointer
    logic        collision_flag;               // Sticky
    logic        abort_flag;                   // Sticky
    logic        finished_flag;                // Sticky
    logic        transfer_enable;              // Start/run bit
    logic [14:0] delay_fields;                 // Delay settings, passed out
    logic        rd_wait;                      // Data read wait state taken
    logic [15:0] ram [0:63];                   // tx, rx, cmd, reserved

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic        req;                          // New cycle, no answer yet
    logic        is_data;                      // Data window addressed
    logic        data_rd;                      // Read of data window
    logic        go;                           // Access takes effect now
    logic        wr;                           // Effective write
    logic        rd;                           // Effective read
    logic [1:0]  lo_sel;                       // Lanes of low half
    logic [15:0] wdat;                         // Low half of write data
    logic [5:0]  ram_idx;                      // Pointer into RAM
    logic [1:0]  ram_sec;                      // RAM section
    logic        ptr_ok;                       // Upper pointer bits clear
    logic        collide;                      // Pointer on executing entry
    logic        col_hit;                      // Colliding data write
    logic        abt_try;                      // CPU tries clearing enable
    logic        abt_hit;                      // ...while a transfer runs
    logic        err_now;                      // Access answered by err
    logic        end_hit;                      // Done entry is the last
    logic        fin_set;                      // Finished event
    logic        hw_clear;                     // Engine ends the transfer
    logic        sw_clear;                     // CPU clears the enable
    logic        ram_we;                       // CPU RAM write strobe
    logic [15:0] next_rdata;                   // Read mux
    logic        clr_ok;                       // Flag clear write, low lane
    logic [15:0] dly_merged;                   // Delay write merged by lane

    assign req     = i_wb_cyc & i_wb_stb & ~o_wb_ack & ~o_wb_err;
    assign is_data = (i_wb_adr == qspi_regs_pkg::OFS_DATA);
    assign data_rd = req & ~i_wb_we & is_data;
    // Data reads wait one extra cycle for the RAM
    assign go      = req & (~data_rd | rd_wait);
    assign wr      = go & i_wb_we;
    assign rd      = go & ~i_wb_we;
    assign lo_sel  = i_wb_sel[1:0];
    assign wdat    = i_wb_dat[15:0];

    assign ram_idx = ram_pointer_reg[5:0];
    assign ram_sec = ram_pointer_reg[5:4];
    assign ptr_ok  = (ram_pointer_reg[15:6] == qspi_regs_pkg::PTR_HI_ZERO);

    // Executing entry is the tx word or command byte of the current entry
    assign collide = transfer_enable & i_busy & ptr_ok
                   & (ram_sec == qspi_regs_pkg::SEC_TX || ram_sec == qspi_regs_pkg::SEC_CMD)
                   & (ram_pointer_reg[3:0] == i_cur_entry);
    assign col_hit = wr & is_data & collide;

    assign abt_try = wr & (i_wb_adr == qspi_regs_pkg::OFS_DLY) & i_wb_sel[1]
                   & ~i_wb_dat[qspi_regs_pkg::B_SPE] & transfer_enable;
    assign abt_hit = abt_try & i_busy;
    assign err_now = (col_hit & irq_status_control[qspi_regs_pkg::B_COL_BE])
                   | (abt_hit & irq_status_control[qspi_regs_pkg::B_ABT_BE]);
    // Lock-out and an errored access both leave the enable alone
    assign sw_clear = abt_try & ~irq_status_control[qspi_regs_pkg::B_ABT_LOCK]
                    & ~err_now;

    // An errored collided write neither stores nor advances
    assign ram_we = wr & is_data & ~err_now & ptr_ok
                  & (ram_sec != qspi_regs_pkg::SEC_RX)
                  & (ram_sec != qspi_regs_pkg::SEC_RSV);
    assign clr_ok     = wr & (i_wb_adr == qspi_regs_pkg::OFS_IRQ) & lo_sel[0];
    assign dly_merged = merge16({1'b0, delay_fields}, wdat, lo_sel);

    // ----------------------------------------
    // Completion events
    // ----------------------------------------
    assign end_hit  = (i_cur_entry == i_end_of_queue_pointer);
    // Every pass over the end entry counts, wrap or not
    assign fin_set  = i_cmd_done & (end_hit | i_halt);
    // Wrap keeps running past the end; halt stops after this command
    assign hw_clear = i_cmd_done & ((end_hit & ~i_wrap_en) | i_halt);

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    // Reserved bits read as zero
    always_comb begin
        next_rdata = qspi_regs_pkg::RST_16;
        unique case (i_wb_adr)
            qspi_regs_pkg::OFS_IRQ: begin
                next_rdata = irq_status_control;
                next_rdata[qspi_regs_pkg::B_COL_F] = collision_flag;
                next_rdata[qspi_regs_pkg::B_ABT_F] = abort_flag;
                next_rdata[qspi_regs_pkg::B_FIN_F] = finished_flag;
            end
            qspi_regs_pkg::OFS_PTR: begin
                next_rdata = ram_pointer_reg;
            end
            qspi_regs_pkg::OFS_DATA: begin
                // Reserved section and bad pointers read zero
                if (ptr_ok && ram_sec == qspi_regs_pkg::SEC_CMD) begin
                    next_rdata = {ram[ram_idx][15:8], qspi_regs_pkg::BYTE_ZERO};
                end else if (ptr_ok && ram_sec != qspi_regs_pkg::SEC_RSV) begin
                    next_rdata = ram[ram_idx];
                end
            end
            qspi_regs_pkg::OFS_DLY: begin
                next_rdata = {transfer_enable, delay_fields};
            end
            default: begin
                next_rdata = qspi_regs_pkg::RST_16;
            end
        endcase
    end

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    // Unmapped offsets are acked and read zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_err <= 1'b0;
            rd_wait  <= 1'b0;
        end else if (i_ce) begin
            o_wb_ack <= go & ~err_now;
            o_wb_err <= go & err_now;
            rd_wait  <= data_rd & ~rd_wait;
        end
    end

    // Read data registered; held until the next read
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wb_dat <= qspi_regs_pkg::RST_32;
        end else if (i_ce && rd) begin
            o_wb_dat <= {16'h0000, next_rdata};
        end
    end

    // ----------------------------------------
    // Control bits
    // ----------------------------------------
    // Only writable control bits are kept; reserved ones stay zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_status_control <= qspi_regs_pkg::RST_16;
        end else if (i_ce && wr && i_wb_adr == qspi_regs_pkg::OFS_IRQ) begin
            irq_status_control <= merge16(irq_status_control, wdat, lo_sel)
                                & qspi_regs_pkg::IRQ_CTRL_MASK;
        end
    end

    // ----------------------------------------
    // Sticky flags
    // ----------------------------------------
    // A set in the same cycle as a clear wins
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            collision_flag <= 1'b0;
            abort_flag     <= 1'b0;
            finished_flag  <= 1'b0;
        end else if (i_ce) begin
            collision_flag <= w1c(collision_flag, clr_ok & wdat[qspi_regs_pkg::B_COL_F],
                                  col_hit);
            abort_flag     <= w1c(abort_flag, clr_ok & wdat[qspi_regs_pkg::B_ABT_F],
                                  sw_clear);
            finished_flag  <= w1c(finished_flag, clr_ok & wdat[qspi_regs_pkg::B_FIN_F],
                                  fin_set);
        end
    end

    // Level interrupt from enabled flags
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= (collision_flag & irq_status_control[qspi_regs_pkg::B_COL_IE])
                   | (abort_flag     & irq_status_control[qspi_regs_pkg::B_ABT_IE])
                   | (finished_flag  & irq_status_control[qspi_regs_pkg::B_FIN_IE]);
        end
    end

    // ----------------------------------------
    // Transfer enable and delays
    // ----------------------------------------
    // CPU set beats an engine clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            transfer_enable <= 1'b0;
            delay_fields    <= 15'h0000;
        end else if (i_ce) begin
            if (hw_clear || sw_clear) begin
                transfer_enable <= 1'b0;
            end
            if (wr && i_wb_adr == qspi_regs_pkg::OFS_DLY) begin
                if (i_wb_sel[1] && i_wb_dat[qspi_regs_pkg::B_SPE]) begin
                    transfer_enable <= 1'b1;
                end
                if (!err_now) begin
                    delay_fields <= dly_merged[qspi_regs_pkg::DLY_W-1:0];
                end
            end
        end
    end

    assign o_transfer_enable = transfer_enable;
    assign o_delay_cfg       = delay_fields;

    // ----------------------------------------
    // RAM pointer
    // ----------------------------------------
    // Plain 16-bit count: no wrap at section ends
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ram_pointer_reg <= qspi_regs_pkg::RST_16;
        end else if (i_ce) begin
            if (wr && i_wb_adr == qspi_regs_pkg::OFS_PTR) begin
                ram_pointer_reg <= merge16(ram_pointer_reg, wdat, lo_sel);
            end else if (go && is_data && !err_now) begin
                ram_pointer_reg <= ram_pointer_reg + qspi_regs_pkg::PTR_STEP;
            end
        end
    end

    // ----------------------------------------
    // RAM
    // ----------------------------------------
    // Engine receive write lands after the CPU write on a clash
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            if (ram_we && ram_sec == qspi_regs_pkg::SEC_CMD) begin
                if (i_wb_sel[1]) begin
                    ram[ram_idx] <= {wdat[15:8], qspi_regs_pkg::BYTE_ZERO};
                end
            end else if (ram_we) begin
                ram[ram_idx] <= merge16(ram[ram_idx], wdat, lo_sel);
            end
            if (i_rx_we) begin
                ram[{qspi_regs_pkg::SEC_RX, i_rx_entry}] <= i_rx_data;
            end
        end
    end

    // Registered engine read port
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_eng_rdata <= qspi_regs_pkg::RST_16;
        end else if (i_ce) begin
            o_eng_rdata <= ram[i_eng_addr];
        end
    end
endmodule : queued_spi_status_and_ram_port

`default_nettype wire

// >>> qspi_status_checker.sv
// Concurrent checks on the status bank's bus answers and transfer enable.
// Assumes i_ce stays high while checks run; bound to the top module below.
`timescale 1ns/1ps
`default_nettype none

module qspi_status_checker (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [4:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [31:0] o_wb_dat,
    input  wire logic        o_wb_ack,
    input  wire logic        o_wb_err,
    input  wire logic        i_busy,
    input  wire logic        i_cmd_done,
    input  wire logic [3:0]  i_cur_entry,
    input  wire logic        i_halt,
    input  wire logic        i_wrap_en,
    input  wire logic [3:0]  i_end_of_queue_pointer,
    input  wire logic        o_transfer_enable,
    input  wire logic        o_irq
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic req;                                  // Request on the bus
    logic last;                                 // Engine reached queue end without wrap
    assign req  = i_wb_cyc && i_wb_stb;
    assign last = (i_cur_entry == i_end_of_queue_pointer) && !i_wrap_en;
    // ----------------------------------------
    // Bus answers
    // ----------------------------------------
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
    a_ack_err_excl: assert property (!(o_wb_ack && o_wb_err)) else $error("ack and err together");
    a_read_wait: assert property ($rose(req) && !i_wb_we && i_wb_adr == qspi_regs_pkg::OFS_DATA
        |=> !o_wb_ack ##1 o_wb_ack) else $error("data read not answered after one wait");
    a_quick_answer: assert property ($rose(req) && (i_wb_we || i_wb_adr != qspi_regs_pkg::OFS_DATA)
        |=> o_wb_ack || o_wb_err) else $error("register access not answered next cycle");
    a_err_cause: assert property (o_wb_err |-> $past(i_wb_we) && $past(i_busy)
        && $past(o_transfer_enable)) else $error("err without busy enabled write");
    a_err_place: assert property (o_wb_err |-> $past(i_wb_adr) == qspi_regs_pkg::OFS_DATA
        || $past(i_wb_adr) == qspi_regs_pkg::OFS_DLY) else $error("err at wrong address");
    a_high_zero: assert property (o_wb_ack |-> o_wb_dat[31:16] == 16'h0000) else $error("upper read bits set");
    // ----------------------------------------
    // Transfer enable
    // ----------------------------------------
    a_enable_done: assert property (o_transfer_enable && i_cmd_done && !req && (last || i_halt)
        |=> !o_transfer_enable) else $error("enable kept after queue end");
    a_enable_keep: assert property (o_transfer_enable && !req && !(i_cmd_done && (last || i_halt))
        |=> o_transfer_enable) else $error("enable dropped without cause");
    a_enable_set: assert property ($rose(o_transfer_enable) |-> $past(req) && $past(i_wb_we) && $past(i_wb_sel[1])
        && $past(i_wb_dat[15]) && $past(i_wb_adr) == qspi_regs_pkg::OFS_DLY) else $error("enable set without write");
    // Main scenarios
    c_data_read: cover property ($rose(req) && !i_wb_we && i_wb_adr == qspi_regs_pkg::OFS_DATA);
    c_err: cover property (o_wb_err);
    c_irq: cover property ($rose(o_irq));
endmodule : qspi_status_checker

bind queued_spi_status_and_ram_port qspi_status_checker u_chk (.i_clk, .i_rst, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_wb_err, .i_busy, .i_cmd_done,
    .i_cur_entry, .i_halt, .i_wrap_en, .i_end_of_queue_pointer, .o_transfer_enable, .o_irq);

`default_nettype wire

// >>> test_queued_spi_status_and_ram_port.sv
// Self-checking bench for the status bank, transfer enable and RAM window.
// Assumes the design's package is compiled first; drives engine inputs itself.
`timescale 1ns/1ps
`default_nettype none

module test_queued_spi_status_and_ram_port;
    logic i_clk = 0, i_rst = 1, i_ce = 1, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
    logic [4:0] i_wb_adr = 5'h00;
    logic [3:0] i_wb_sel = 4'h3;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat;
    logic o_wb_ack, o_wb_err, i_busy = 0, i_cmd_done = 0, i_halt = 0, i_wrap_en = 0, i_rx_we = 0;
    logic [3:0] i_cur_entry = 4'h0, i_end_of_queue_pointer = 4'h0, i_rx_entry = 4'h0;
    logic [5:0] i_eng_addr = 6'h00;
    logic [15:0] o_eng_rdata, i_rx_data = 16'h0;
    logic o_transfer_enable, o_irq;
    logic [14:0] o_delay_cfg;
    int failures = 0, total_checks = 0;
    logic [3:0] lanes = 4'h3;                   // Byte lanes of the next request
    localparam logic [4:0] IRQ = qspi_regs_pkg::OFS_IRQ, PTR = qspi_regs_pkg::OFS_PTR;
    localparam logic [4:0] DAT = qspi_regs_pkg::OFS_DATA, DLY = qspi_regs_pkg::OFS_DLY;

    queued_spi_status_and_ram_port dut (.i_clk, .i_rst, .i_ce, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
        .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_wb_err, .i_busy, .i_cmd_done, .i_cur_entry, .i_halt,
        .i_wrap_en, .i_end_of_queue_pointer, .i_eng_addr, .o_eng_rdata, .i_rx_we, .i_rx_entry, .i_rx_data,
        .o_transfer_enable, .o_delay_cfg, .o_irq);

    always #5 i_clk = ~i_clk;                   // 100 MHz

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One classic cycle; held until ack or err is sampled, then released
    task automatic wb(input logic we, input logic [4:0] adr, input logic [15:0] d, input logic e,
                      output logic [31:0] rd);
        int n;
        i_wb_cyc <= 1; i_wb_stb <= 1; i_wb_we <= we; i_wb_adr <= adr; i_wb_dat <= {16'h0000, d}; i_wb_sel <= lanes;
        for (n = 0; n < 20; n++) begin
            @(posedge i_clk);
            if (o_wb_ack === 1'b1 || o_wb_err === 1'b1) break;
        end
        if (n == 20) begin
            failures++;
            give_verdict();
        end
        check("err", o_wb_err, e);
        rd = o_wb_dat;
        i_wb_cyc <= 0; i_wb_stb <= 0; i_wb_we <= 0;
        @(posedge i_clk);                        // Idle cycle between requests
    endtask : wb

    task automatic wr(input logic [4:0] adr, input logic [15:0] d);
        logic [31:0] rd;
        wb(1, adr, d, 0, rd);
    endtask : wr

    task automatic rdc(input string name, input logic [4:0] adr, input logic [15:0] exp);
        logic [31:0] rd;
        wb(0, adr, 16'h0000, 0, rd);
        check(name, rd, {16'h0000, exp});
    endtask : rdc

    // Engine completion pulse, then let flags and irq settle
    task automatic done_pulse();
        i_cmd_done <= 1;
        @(posedge i_clk);
        i_cmd_done <= 0;
        repeat (2) @(posedge i_clk);
    endtask : done_pulse

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_reset_and_unmapped();
        rdc("irq reg", IRQ, 16'h0000);
        rdc("ptr reg", PTR, 16'h0000);
        rdc("dly reg", DLY, 16'h0000);
        wr(5'h10, 16'hffff);                    // Unmapped write is ignored
        rdc("unmapped", 5'h10, 16'h0000);
    endtask : s_reset_and_unmapped

    task automatic s_ram_window();
        wr(PTR, 16'h000e);
        wr(DAT, 16'h1111);
        wr(DAT, 16'h2222);
        rdc("ptr past tx", PTR, 16'h0010);
        i_rx_we <= 1; i_rx_data <= 16'h5a5a; i_eng_addr <= 6'h0e;
        @(posedge i_clk);
        i_rx_we <= 0;
        repeat (2) @(posedge i_clk);
        check("eng read", o_eng_rdata, 32'h1111);
        lanes = 4'h1;                           // Low lane only: high bytes kept
        wr(PTR, 16'h000e);
        wr(DAT, 16'hffee);
        lanes = 4'h3;
        wr(PTR, 16'h000e);
        rdc("tx word", DAT, 16'h11ee);
        rdc("tx next", DAT, 16'h2222);
        rdc("rx word", DAT, 16'h5a5a);
        rdc("ptr after rd", PTR, 16'h0011);
        wr(PTR, 16'h0020);
        wr(DAT, 16'habcd);
        wr(PTR, 16'h0030);
        wr(DAT, 16'h7777);
        wr(PTR, 16'h0020);
        rdc("cmd byte", DAT, 16'hab00);
        wr(PTR, 16'h0030);
        rdc("reserved", DAT, 16'h0000);
    endtask : s_ram_window

    task automatic s_collision();
        logic [31:0] rd;
        wr(DLY, 16'h8123);
        i_busy <= 1; i_cur_entry <= 4'h3;
        wr(PTR, 16'h0003);
        wr(DAT, 16'h1234);
        rdc("col flag", IRQ, 16'h0008);
        rdc("col ptr", PTR, 16'h0004);
        wr(IRQ, 16'h0000);
        rdc("w0 keeps", IRQ, 16'h0008);
        check("irq gated", o_irq, 0);
        wr(IRQ, 16'h8808);
        rdc("w1 clears", IRQ, 16'h8800);
        check("irq off", o_irq, 0);
        wr(PTR, 16'h0003);
        wb(1, DAT, 16'hbeef, 1, rd);
        rdc("err ptr", PTR, 16'h0003);
        rdc("err flag", IRQ, 16'h8808);
        check("col irq", o_irq, 1);
        wr(IRQ, 16'h0008);
        rdc("ram kept", DAT, 16'h1234);
        check("irq clear", o_irq, 0);
    endtask : s_collision

    task automatic s_abort();
        logic [31:0] rd;
        wr(IRQ, 16'h4000);
        wb(1, DLY, 16'h0000, 1, rd);
        rdc("abort err", DLY, 16'h8123);
        check("dly out", o_delay_cfg, 32'h0123);
        wr(IRQ, 16'h1000);
        wr(DLY, 16'h0000);
        rdc("locked", DLY, 16'h8000);
        rdc("no abort", IRQ, 16'h1000);
        wr(IRQ, 16'h0400);
        wr(DLY, 16'h0000);
        rdc("abort clr", DLY, 16'h0000);
        rdc("abort flag", IRQ, 16'h0404);
        check("abort irq", o_irq, 1);
        wr(IRQ, 16'h0004);
        i_busy <= 0;
    endtask : s_abort

    task automatic s_finished();
        wr(IRQ, 16'h0100);
        i_cur_entry <= 4'h5; i_end_of_queue_pointer <= 4'h5;
        i_ce <= 0; done_pulse(); i_ce <= 1;    // Frozen: completion is lost
        rdc("ce freeze", IRQ, 16'h0100);
        wr(DLY, 16'h8000);
        done_pulse();
        check("end clears", o_transfer_enable, 0);
        check("fin irq", o_irq, 1);
        rdc("fin flag", IRQ, 16'h0101);
        wr(IRQ, 16'h0101);
        i_wrap_en <= 1;
        wr(DLY, 16'h8000);
        done_pulse();
        wr(IRQ, 16'h0101);
        done_pulse();
        rdc("wrap again", IRQ, 16'h0101);
        check("wrap runs", o_transfer_enable, 1);
        i_wrap_en <= 0; i_halt <= 1; i_cur_entry <= 4'h2;
        wr(IRQ, 16'h0001);
        done_pulse();
        rdc("halt flag", IRQ, 16'h0001);
        check("halt stop", o_transfer_enable, 0);
    endtask : s_finished

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 0;
        @(posedge i_clk);
        s_reset_and_unmapped();
        s_ram_window();
        s_collision();
        s_abort();
        s_finished();
        give_verdict();
    end
endmodule : test_queued_spi_status_and_ram_port

`default_nettype wire
